// ===== cdrom_decoder_ctrl_status.sv
// Decoder control and status register bank with block sync supervision
// Overview of operation
// - Decode enable low disables the decoder whatever the other mode bits say.
// - Enabled mode comes from look-ahead, buffer-write and correction bits.
// - Any reset clears every bit of the configuration register.
// - Config bit 7 inserts missing syncs so block timing is kept.
// - Config bit 6 retimes block timing to detected syncs; else detection off.
// - Config bit 5 enables descrambling; clear passes raw data.
// - Config bit 4 lets corrected bytes be rewritten; clear means check only.
// - Config bit 3 requests Mode 2, bit 2 requests Form 2.
// - With mode check on, a mode byte mismatch disables correction and detection.
// - Config bit 0 shows sub-header instead of header in the four read registers.
// - Chip reset clears block status and header error status.
// - Status bit 7 shows the block CRC passed.
// - Status bit 6 marks a sync at a wrong word count that retimed the decoder.
// - Correction stops for long blocks as well as misplaced syncs.
// - Status bit 5 marks the word counter reaching 1175 with no sync seen.
// - Status bit 4 marks needed insertion with interpolation off; block extends.
// - Status bit 2 marks a wrong-place sync that did not retime; off if detect off.
// - Status bit 1 marks any erasure-flagged byte in the block.
// - Status bit 0 marks bytes still in error after correction.
// - Header error bits 7-4 cover header bytes, bits 3-0 sub-header bytes.
// - Decode enable low also suppresses the decoder interrupt.
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module cdrom_decoder_ctrl_status
    import decoder_regs_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    input wire logic word_strobe,
    input wire logic sync_found,
    input wire logic erasure_flag_input,
    input wire logic crc_done,
    input wire logic crc_good,
    input wire logic correction_done,
    input wire logic bytes_in_error,
    input wire logic [7:0] mode_byte,
    input wire logic [7:0] header_error_flags,
    input wire logic [7:0] header_bytes [NUM_HEADER_READ],
    input wire logic [7:0] subheader_bytes [NUM_HEADER_READ],
    input wire logic block_event,
    output var decoder_mode_t decoder_mode,
    output var decoder_config_t config_out,
    output logic correction_allowed,
    output logic detection_allowed,
    output logic block_start,
    output logic decoder_irq
);

    // ============================================================
    // Mode decode, used only by the registered mode output; readback returns the raw mode register
    function automatic decoder_mode_t decode_mode(input logic [7:0] m);
        logic [2:0] sel;
        sel = {m[BIT_LOOKAHEAD], m[BIT_BUFFER_WRITE_REQUEST], m[BIT_CORRECTION_REQUEST]};
        if (!m[BIT_DECODE_ENABLE])
            return MODE_DISABLED;
        unique case (sel)
            3'h0: return MODE_MONITOR;
            3'h1: return MODE_REPEAT_CORRECT;
            3'h2: return MODE_WRITE_ONLY;
            3'h3: return MODE_REALTIME_NORMAL;
            3'h6: return MODE_WRITE_LOOKAHEAD;
            3'h7: return MODE_REALTIME_LOOKAHEAD;
            default: return MODE_UNDEFINED; // Look-ahead without writes is not a mode
        endcase
    endfunction

    // ============================================================
    // Pin input synchronisers
    logic [1:0] sync_found_meta;
    logic [1:0] erasure_meta;
    logic sync_found_s;
    logic erasure_s;

    // Two stages; only the second stage is read by logic
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            sync_found_meta <= 2'h0;
        else
            sync_found_meta <= {sync_found_meta[0], sync_found};
    end

    // Erasure pin gets its own pair; the flag accumulates until block end
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            erasure_meta <= 2'h0;
        else
            erasure_meta <= {erasure_meta[0], erasure_flag_input};
    end
    assign sync_found_s = sync_found_meta[1];
    assign erasure_s = erasure_meta[1];

    // ============================================================
    // Registers
    logic [7:0] mode_reg;
    decoder_config_t cfg;
    block_status_t status;
    header_error_t hdr_err;
    logic [11:0] word_count;
    logic misplaced_acc;
    logic inserted_acc;
    logic long_acc;
    logic short_acc;
    logic erasure_acc;
    logic mismatch;

    // Software writes of mode and configuration
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mode_reg <= DECODER_MODE_RESET;
            cfg <= DECODER_CONFIG_RESET;
        end
        else if (wr_en)
        begin
            if (addr == ADDR_DECODER_MODE)
                mode_reg <= wdata[7:0];
            if (addr == ADDR_DECODER_CONFIG)
                cfg <= wdata[7:0];
        end
    end

    // ============================================================
    // Word counter and block timing
    logic at_sync_pos;
    logic wrong_sync;
    logic retime_hit;
    assign at_sync_pos = (word_count == SYNC_WORD_POS);
    // Sync detection gated by its enable
    assign retime_hit = word_strobe && sync_found_s && cfg.sync_detect_enable;
    // Retime away from the sync slot: the block was misplaced
    assign wrong_sync = retime_hit && !at_sync_pos;

    // Counter restarts on retime, on interpolated sync, or runs on for long blocks
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            word_count <= COUNT_ZERO;
        else if (word_strobe)
        begin
            if (sync_found_s && cfg.sync_detect_enable)
                word_count <= COUNT_ZERO;
            else if (at_sync_pos && cfg.sync_interp_enable)
                word_count <= COUNT_ZERO;
            else if (word_count != 12'hFFF)
                word_count <= word_count + COUNT_ONE;
        end
    end

    // Start pulse whenever a new block begins
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            block_start <= 1'b0;
        else
            block_start <= retime_hit || (word_strobe && at_sync_pos && cfg.sync_interp_enable);
    end

    // ============================================================
    // Per-block accumulation of sync and erasure events
    logic insert_hit;
    logic long_hit;
    logic short_hit;
    // Counter at the sync slot with no sync seen: a sync is missing, interpolation on or off
    assign insert_hit = word_strobe && at_sync_pos && !sync_found_s;
    // Same case with interpolation off; the block runs long instead
    assign long_hit = insert_hit && !cfg.sync_interp_enable;
    // Sync out of place while detection is off, so timing is not retimed
    assign short_hit = word_strobe && sync_found_s && !at_sync_pos && !cfg.sync_detect_enable;

    // Each flag restarts at block end; a coincident event wins and seeds the next block
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            misplaced_acc <= 1'b0;
        else if (wrong_sync)
            misplaced_acc <= 1'b1;
        else if (block_event)
            misplaced_acc <= 1'b0;
    end

    // Sync slot reached with no sync seen in this block, interpolation on or off
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            inserted_acc <= 1'b0;
        else if (insert_hit)
            inserted_acc <= 1'b1;
        else if (block_event)
            inserted_acc <= 1'b0;
    end

    // Block extended because insertion was off
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            long_acc <= 1'b0;
        else if (long_hit)
            long_acc <= 1'b1;
        else if (block_event)
            long_acc <= 1'b0;
    end

    // Sync seen out of place without retiming: block ends short
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            short_acc <= 1'b0;
        else if (short_hit)
            short_acc <= 1'b1;
        else if (block_event)
            short_acc <= 1'b0;
    end

    // Any erasure-flagged byte in the block
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            erasure_acc <= 1'b0;
        else if (erasure_s)
            erasure_acc <= 1'b1;
        else if (block_event)
            erasure_acc <= 1'b0;
    end

    // ============================================================
    // Correction gating
    assign mismatch = cfg.mode_check_enable && (mode_byte[1:0] != {cfg.mode_request, ~cfg.mode_request});

    // Correction blocked on bad sync timing or mode mismatch
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            correction_allowed <= 1'b0;
        else
            correction_allowed <= mode_reg[BIT_CORRECTION_REQUEST] && mode_reg[BIT_DECODE_ENABLE]
                                  && !misplaced_acc && !long_acc && !mismatch;
    end

    // Detection survives bad sync timing; only the mode check or decode enable low stops it
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            detection_allowed <= 1'b0;
        else
            detection_allowed <= mode_reg[BIT_DECODE_ENABLE] && !mismatch;
    end

    // ============================================================
    // Status latched at block end, held until the next
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            status <= STATUS_RESET;
            hdr_err <= STATUS_RESET;
        end
        else if (block_event)
        begin
            status.crc_pass <= crc_done && crc_good;
            status.misplaced_sync <= misplaced_acc;
            status.sync_inserted <= inserted_acc;
            status.long_block <= long_acc;
            status.reserved <= 1'b0;
            status.short_block <= short_acc && cfg.sync_detect_enable;
            status.erasure_in_block <= erasure_acc;
            status.uncorrectable_block <= correction_done && bytes_in_error;
            hdr_err <= header_error_flags;
        end
    end

    // Interrupt only while decoding is on
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            decoder_irq <= 1'b0;
        else
            decoder_irq <= block_event && mode_reg[BIT_DECODE_ENABLE];
    end

    // Registered copy of the decoded mode for the datapath
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            decoder_mode <= MODE_DISABLED;
        else
            decoder_mode <= decode_mode(mode_reg);
    end

    // Registered copy of the configuration, one cycle behind the register
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            config_out <= DECODER_CONFIG_RESET;
        else
            config_out <= cfg;
    end

    // ============================================================
    // Read path, data one cycle after the strobe
    // Header or sub-header view, one byte lane per read register
    logic [7:0] head_view [NUM_HEADER_READ];
    genvar g;
    generate
        for (g = 0; g < NUM_HEADER_READ; g = g + 1)
        begin : g_head_view
            assign head_view[g] = cfg.subheader_select ? subheader_bytes[g]
                                  : header_bytes[g];
        end
    endgenerate

    logic [31:0] next_rdata;
    always_comb
    begin
        next_rdata = UNMAPPED_READ;
        unique case (addr)
            ADDR_DECODER_MODE: next_rdata = {24'h000000, mode_reg};
            ADDR_DECODER_CONFIG: next_rdata = {24'h000000, cfg};
            ADDR_BLOCK_STATUS: next_rdata = {24'h000000, status};
            ADDR_HEADER_ERROR_STATUS: next_rdata = {24'h000000, hdr_err};
            default:
            begin
                for (int i = 0; i < NUM_HEADER_READ; i++)
                    if (addr == ADDR_HEADER_READ_0 + 8'(4 * i))
                        next_rdata = {24'h000000, head_view[i]};
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            rdata <= UNMAPPED_READ;
        else if (rd_en)
            rdata <= next_rdata;
        else
            rdata <= UNMAPPED_READ;
    end

endmodule

`default_nettype wire

// ===== decoder_regs_pkg.sv
// Constants and carrier types for the decoder control and status registers
package decoder_regs_pkg;

    // ============================================================
    // Register map, byte addresses
    localparam logic [7:0] ADDR_DECODER_MODE = 8'h00;
    localparam logic [7:0] ADDR_DECODER_CONFIG = 8'h04;
    localparam logic [7:0] ADDR_BLOCK_STATUS = 8'h08;
    localparam logic [7:0] ADDR_HEADER_ERROR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_HEADER_READ_0 = 8'h10;
    localparam int NUM_HEADER_READ = 4;

    // ============================================================
    // Reset values
    localparam logic [7:0] DECODER_MODE_RESET = 8'h00;
    localparam logic [7:0] DECODER_CONFIG_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // ============================================================
    // Mode register field positions
    localparam int BIT_DECODE_ENABLE = 7;
    localparam int BIT_LOOKAHEAD = 6;
    localparam int BIT_BUFFER_WRITE_REQUEST = 2;
    localparam int BIT_CORRECTION_REQUEST = 1;

    // ============================================================
    // Block timing counts in words
    localparam logic [11:0] SYNC_WORD_POS = 12'h497;
    localparam logic [11:0] COUNT_ZERO = 12'h000;
    localparam logic [11:0] COUNT_ONE = 12'h001;

    // Configuration register layout, bit 7 down to bit 0
    typedef struct packed {
        logic sync_interp_enable;
        logic sync_detect_enable;
        logic descramble_enable;
        logic correction_writeback_enable;
        logic mode_request;
        logic form_request;
        logic mode_check_enable;
        logic subheader_select;
    } decoder_config_t;

    // Block status layout, bit 7 down to bit 0
    typedef struct packed {
        logic crc_pass;
        logic misplaced_sync;
        logic sync_inserted;
        logic long_block;
        logic reserved;
        logic short_block;
        logic erasure_in_block;
        logic uncorrectable_block;
    } block_status_t;

    // Header error layout, bit 7 down to bit 0
    typedef struct packed {
        logic minutes_byte_error;
        logic seconds_byte_error;
        logic frames_byte_error;
        logic mode_byte_error;
        logic subhdr_byte0_error;
        logic subhdr_byte1_error;
        logic subhdr_byte2_error;
        logic subhdr_byte3_error;
    } header_error_t;

    typedef enum {
        MODE_DISABLED,
        MODE_MONITOR,
        MODE_REPEAT_CORRECT,
        MODE_WRITE_ONLY,
        MODE_REALTIME_NORMAL,
        MODE_WRITE_LOOKAHEAD,
        MODE_REALTIME_LOOKAHEAD,
        MODE_UNDEFINED
    } decoder_mode_t;

endpackage

// ===== cdrom_decoder_ctrl_status_properties.sv
// Port-level checks for the decoder control and status register bank
`timescale 1ns/1ps
`default_nettype none

module cdrom_decoder_ctrl_status_properties
    import decoder_regs_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rdata,
    input wire logic block_event,
    input wire logic [7:0] mode_byte,
    input var decoder_mode_t decoder_mode,
    input wire decoder_config_t config_out,
    input wire logic correction_allowed,
    input wire logic detection_allowed,
    input wire logic decoder_irq
);
    // ============================================================
    // Helpers
    logic [7:0] wlow;
    logic mm;
    assign wlow = wdata[7:0];
    // Mode byte disagrees with requested mode while the check is on
    assign mm = config_out.mode_check_enable &&
        (mode_byte[1:0] != (config_out.mode_request ? 2'h2 : 2'h1));

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    // ============================================================
    // Read port
    property p_rdata_idle;
        !$past(rd_en) |-> rdata == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    property p_unmapped;
        rd_en && (addr > ADDR_HEADER_READ_0 + 8'h0C || addr[1:0] != 2'h0) |=>
            rdata == UNMAPPED_READ;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_upper;
        rd_en |=> rdata[31:8] == 24'h00_0000;
    endproperty
    a_upper: assert property (p_upper) else $error("upper read bits not zero");
    property p_reserved;
        rd_en && addr == ADDR_BLOCK_STATUS |=> rdata[3] == 1'b0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    // ============================================================
    // Mode and configuration
    property p_disabled;
        wr_en && addr == ADDR_DECODER_MODE && !wdata[BIT_DECODE_ENABLE] |->
            ##2 decoder_mode == MODE_DISABLED;
    endproperty
    a_disabled: assert property (p_disabled) else $error("decoder not disabled");
    property p_normal;
        wr_en && addr == ADDR_DECODER_MODE && wdata[7:6] == 2'h2 && wdata[2:1] == 2'h3 |->
            ##2 decoder_mode == MODE_REALTIME_NORMAL;
    endproperty
    a_normal: assert property (p_normal) else $error("wrong real-time mode");
    property p_config_copy;
        wr_en && addr == ADDR_DECODER_CONFIG |-> ##2 config_out == $past(wlow, 2);
    endproperty
    a_config_copy: assert property (p_config_copy) else $error("config not copied");
    // Mismatch must hold a few cycles; the gating is registered
    property p_modechk;
        mm [*3] |-> !correction_allowed && !detection_allowed;
    endproperty
    a_modechk: assert property (p_modechk) else $error("mode mismatch not gated");

    // ============================================================
    // Interrupt pulse
    property p_irq_on;
        block_event && decoder_mode != MODE_DISABLED ##1 decoder_mode != MODE_DISABLED |->
            decoder_irq;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("missing interrupt");
    property p_irq_off;
        block_event && decoder_mode == MODE_DISABLED ##1 decoder_mode == MODE_DISABLED |->
            !decoder_irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");
endmodule

`default_nettype wire

// ===== cdrom_decoder_ctrl_status_tb.sv
// Self-checking bench for the decoder control and status register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            error_cnt++; \
            $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end

module cdrom_decoder_ctrl_status_tb
    import decoder_regs_pkg::*;
;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [31:0] rdata;
    logic word_strobe = 1'b0;
    logic sync_found = 1'b0;
    logic erasure = 1'b0;
    logic crc_done = 1'b0;
    logic crc_good = 1'b0;
    logic corr_done = 1'b0;
    logic bytes_err = 1'b0;
    logic [7:0] mode_byte = 8'h00;
    logic [7:0] hdr_err = 8'h00;
    logic [7:0] hdr_b [NUM_HEADER_READ];
    logic [7:0] sub_b [NUM_HEADER_READ];
    logic block_event = 1'b0;
    decoder_mode_t decoder_mode;
    decoder_config_t config_out;
    logic correction_allowed;
    logic detection_allowed;
    logic block_start;
    logic decoder_irq;
    int error_cnt = 0;
    int n_tests = 0;
    int cycles = 0;
    int starts = 0;

    cdrom_decoder_ctrl_status uut (.mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .word_strobe(word_strobe),
        .sync_found(sync_found), .erasure_flag_input(erasure), .crc_done(crc_done),
        .crc_good(crc_good), .correction_done(corr_done), .bytes_in_error(bytes_err),
        .mode_byte(mode_byte), .header_error_flags(hdr_err), .header_bytes(hdr_b),
        .subheader_bytes(sub_b), .block_event(block_event), .decoder_mode(decoder_mode),
        .config_out(config_out), .correction_allowed(correction_allowed),
        .detection_allowed(detection_allowed), .block_start(block_start),
        .decoder_irq(decoder_irq));

    // ============================================================
    // Clock and hang guard
    initial
    begin
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            error_cnt++;
            conclude();
        end
    end

    // Block start pulses, counted as they stand
    always @(posedge mclk)
    begin
        if (block_start)
            starts <= starts + 1;
    end

    // ============================================================
    // Tasks
    task automatic conclude();
        if (error_cnt == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= {24'h00_0000, d};
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1;
        `CHK(rdata, exp)
    endtask
    // Erasure dropped well before the end so it cannot seed the next block
    task automatic blk(input logic good, input logic era, input logic [7:0] he);
        @(posedge mclk);
        erasure <= era;
        crc_done <= 1'b1;
        crc_good <= good;
        corr_done <= 1'b1;
        bytes_err <= era;
        hdr_err <= he;
        repeat (4) @(posedge mclk);
        erasure <= 1'b0;
        repeat (3) @(posedge mclk);
        block_event <= 1'b1;
        @(posedge mclk);
        block_event <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    // One word per cycle; sync pin high for word s only, -1 for none
    task automatic words(input int n, input int s);
        for (int i = 0; i < n; i++)
        begin
            @(posedge mclk);
            word_strobe <= 1'b1;
            sync_found <= (i == s);
        end
        @(posedge mclk);
        word_strobe <= 1'b0;
        sync_found <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask
    function automatic decoder_mode_t exp_mode(input logic [3:0] m);
        casez (m)
            4'b0???: return MODE_DISABLED;
            4'b1000: return MODE_MONITOR;
            4'b1001: return MODE_REPEAT_CORRECT;
            4'b1010: return MODE_WRITE_ONLY;
            4'b1011: return MODE_REALTIME_NORMAL;
            4'b1110: return MODE_WRITE_LOOKAHEAD;
            4'b1111: return MODE_REALTIME_LOOKAHEAD;
            default: return MODE_UNDEFINED;
        endcase
    endfunction

    // ============================================================
    // Main sequence
    initial
    begin
        for (int i = 0; i < NUM_HEADER_READ; i++)
        begin
            hdr_b[i] = 8'hC0 + 8'(i);
            sub_b[i] = 8'hD0 + 8'(i);
        end
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        rd(ADDR_DECODER_CONFIG, 32'h0000_0000);
        rd(ADDR_BLOCK_STATUS, 32'h0000_0000);
        rd(ADDR_HEADER_ERROR_STATUS, 32'h0000_0000);
        rd(8'h20, UNMAPPED_READ);
        rd(8'h06, UNMAPPED_READ);
        wr(ADDR_DECODER_CONFIG, 8'hA5);
        wr(8'h24, 8'h5A);
        rd(ADDR_DECODER_CONFIG, 32'h0000_00A5);
        `CHK(config_out, 8'hA5)
        // Every combination of the four mode bits
        for (int m = 0; m < 16; m++)
        begin
            wr(ADDR_DECODER_MODE, {m[3], m[2], 3'h0, m[1], m[0], 1'b0});
            repeat (3) @(posedge mclk);
            `CHK(decoder_mode, exp_mode(4'(m)))
        end
        wr(ADDR_DECODER_MODE, 8'h86);
        blk(1'b1, 1'b1, 8'h5A);
        rd(ADDR_BLOCK_STATUS, 32'h0000_0083);
        rd(ADDR_HEADER_ERROR_STATUS, 32'h0000_005A);
        for (int i = 0; i < NUM_HEADER_READ; i++)
            rd(ADDR_HEADER_READ_0 + 8'(4 * i), {24'h00_0000, sub_b[i]});
        wr(ADDR_DECODER_CONFIG, 8'h00);
        blk(1'b0, 1'b0, 8'hA1);
        repeat (20) @(posedge mclk);
        rd(ADDR_BLOCK_STATUS, 32'h0000_0000);
        rd(ADDR_HEADER_ERROR_STATUS, 32'h0000_00A1);
        for (int i = 0; i < NUM_HEADER_READ; i++)
            rd(ADDR_HEADER_READ_0 + 8'(4 * i), {24'h00_0000, hdr_b[i]});
        `CHK(correction_allowed, 1'b1)
        `CHK(detection_allowed, 1'b1)
        // Mode 1 requested while the block claims mode 2
        wr(ADDR_DECODER_CONFIG, 8'h02);
        mode_byte <= 8'h02;
        repeat (5) @(posedge mclk);
        `CHK(correction_allowed, 1'b0)
        `CHK(detection_allowed, 1'b0)
        // Block claims mode 1 as well: gating lifts
        mode_byte <= 8'h01;
        repeat (5) @(posedge mclk);
        `CHK(correction_allowed, 1'b1)
        // Interpolated sync at word 1175, then a block that runs long
        wr(ADDR_DECODER_CONFIG, 8'h80);
        words(1180, -1);
        `CHK(correction_allowed, 1'b1)
        blk(1'b1, 1'b0, 8'h00);
        rd(ADDR_BLOCK_STATUS, 32'h0000_00A0);
        wr(ADDR_DECODER_CONFIG, 8'h00);
        words(1180, -1);
        `CHK(correction_allowed, 1'b0)
        blk(1'b1, 1'b0, 8'h00);
        rd(ADDR_BLOCK_STATUS, 32'h0000_00B0);
        // Detected sync out of place retimes the block
        wr(ADDR_DECODER_CONFIG, 8'h40);
        words(20, 4);
        `CHK(correction_allowed, 1'b0)
        blk(1'b1, 1'b0, 8'h00);
        rd(ADDR_BLOCK_STATUS, 32'h0000_00C0);
        // Undetected sync out of place; flag reported once detection is on
        wr(ADDR_DECODER_CONFIG, 8'h80);
        words(20, 4);
        wr(ADDR_DECODER_CONFIG, 8'hC0);
        blk(1'b1, 1'b0, 8'h00);
        rd(ADDR_BLOCK_STATUS, 32'h0000_0084);
        `CHK(starts, 2)
        wr(ADDR_DECODER_MODE, 8'h00);
        blk(1'b1, 1'b0, 8'h00);
        // Second reset in mid-run
        wr(ADDR_DECODER_CONFIG, 8'hFF);
        @(posedge mclk);
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        rd(ADDR_DECODER_CONFIG, 32'h0000_0000);
        rd(ADDR_BLOCK_STATUS, 32'h0000_0000);
        conclude();
    end
endmodule

bind cdrom_decoder_ctrl_status cdrom_decoder_ctrl_status_properties chk (.mclk(mclk),
    .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .block_event(block_event), .mode_byte(mode_byte),
    .decoder_mode(decoder_mode), .config_out(config_out),
    .correction_allowed(correction_allowed), .detection_allowed(detection_allowed),
    .decoder_irq(decoder_irq));

`default_nettype wire
